// File: core/phy_status_irq_control.sv
// Status summary, interrupt control and event registers of one port.
// Assumes register accesses arrive already decoded from the serial
// management frame: one-cycle read or write strobes with a 5-bit address.
`timescale 1ns/100ps
`include "phy_stat_defs.svh"
module phy_status_irq_control (
  // Clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     sys_rst,
  // Decoded management register access
  input  wire phy_stat_pkg::reg_addr_t  reg_addr,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire phy_stat_pkg::mgmt_word_t reg_wdata,
  output      phy_stat_pkg::mgmt_word_t reg_rdata_q,
  output      logic                     reg_rvalid_q,
  // Live port state
  input  wire logic                     jabber_live,
  input  wire logic                     aneg_done,
  input  wire logic                     loopback_on,
  input  wire logic                     duplex_full,
  input  wire logic                     speed_is_10,
  input  wire logic                     link_up,
  input  wire logic                     energy_seen,
  input  wire logic                     link_quality_evt,
  input  wire logic                     fc_cnt_half,
  input  wire logic                     rxerr_cnt_half,
  // Shared power-down / interrupt pin, active low
  input  wire logic                     pwrdn_irq_pin_i_n,
  output      logic                     pwrdn_irq_pin_o_n_q,
  output      logic                     pwrdn_irq_pin_oe_q,
  output      logic                     power_down_q
);
  import phy_stat_pkg::*;

  logic [5:0] live_q;
  logic [5:0] live_prev_q;
  logic       energy_q;
  logic [1:0] half_q;
  ctl_vec_t   ctl_q;
  evt_vec_t   evt_en_q;
  evt_vec_t   evt_stat_q;
  logic       irq_q;

  // Address decode and strobes
  wire        hit_sum = (reg_addr == `ADDR_STATUS_SUMMARY);
  wire        hit_ctl = (reg_addr == `ADDR_INT_CONTROL);
  wire        hit_evt = (reg_addr == `ADDR_INT_EVENT);
  wire        wr_ctl  = reg_wr & hit_ctl;
  wire        wr_evt  = reg_wr & hit_evt;
  wire        rd_evt  = reg_rd & hit_evt;

  // Live state snapshot in summary bit order
  wire [5:0]  live_d = {jabber_live, aneg_done, loopback_on,
                        duplex_full, speed_is_10, link_up};

  // Event pulses from edges of live state; link quality event passed straight through
  evt_vec_t   evt_pulse;
  assign evt_pulse[`EVT_LQ]     = link_quality_evt;
  assign evt_pulse[`EVT_ENERGY] = energy_seen ^ energy_q;
  assign evt_pulse[`EVT_LINK]   = live_q[`SUM_LINK]
                                ^ live_prev_q[`SUM_LINK];
  assign evt_pulse[`EVT_SPEED]  = live_q[`SUM_SPEED10]
                                ^ live_prev_q[`SUM_SPEED10];
  assign evt_pulse[`EVT_DUPLEX] = live_q[`SUM_DUPLEX]
                                ^ live_prev_q[`SUM_DUPLEX];
  assign evt_pulse[`EVT_ANEG]   = live_q[`SUM_ANEG]
                                & ~live_prev_q[`SUM_ANEG];
  assign evt_pulse[`EVT_FC_HF]  = fc_cnt_half & ~half_q[1];
  assign evt_pulse[`EVT_RX_HF]  = rxerr_cnt_half & ~half_q[0];

  // Interrupt request: forced test, or globally enabled pending event
  wire        evt_irq = ctl_q[`CTL_EVT_EN] & |(evt_stat_q & evt_en_q);
  wire        irq_d   = ctl_q[`CTL_TEST] | evt_irq;

  // Read data; unused bits read zero
  mgmt_word_t sum_word;
  mgmt_word_t ctl_word;
  mgmt_word_t evt_word;
  mgmt_word_t rdata_d;
  assign sum_word = {8'h00, irq_q, 1'b0, live_q};
  assign ctl_word = {13'h0000, ctl_q};
  assign evt_word = {evt_stat_q, evt_en_q};
  assign rdata_d  = !reg_rd ? reg_rdata_q :
                    hit_sum ? sum_word :
                    hit_ctl ? ctl_word :
                    hit_evt ? evt_word : `WORD_ZERO;

  // Sticky event flags, cleared by reading the event register
  phy_evt_latch u_evt (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .evt_pulse  (evt_pulse),
    .clr_rd     (rd_evt),
    .evt_stat_q (evt_stat_q)
  );

  // Live state registered once so reset shows zero
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_q      <= 6'h00;
      live_prev_q <= 6'h00;
      energy_q    <= 1'b0;
      half_q      <= 2'h0;
    end else begin
      live_q      <= live_d;
      live_prev_q <= live_q;
      energy_q    <= energy_seen;
      half_q      <= {fc_cnt_half, rxerr_cnt_half};
    end
  end

  // Writable controls; only the three low control bits are kept
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_q    <= `CTL_ZERO;
      evt_en_q <= `EVT_ZERO;
    end else begin
      if (wr_ctl) begin
        ctl_q <= reg_wdata[`CTL_WIDTH-1:0];
      end
      if (wr_evt) begin
        evt_en_q <= reg_wdata[`EVT_COUNT-1:0];
      end
    end
  end

  // Read return, interrupt and pin; pin sampled only as an input
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q         <= `WORD_ZERO;
      reg_rvalid_q        <= 1'b0;
      irq_q               <= 1'b0;
      pwrdn_irq_pin_o_n_q <= 1'b1;
      pwrdn_irq_pin_oe_q  <= 1'b0;
      power_down_q        <= 1'b0;
    end else begin
      reg_rdata_q         <= rdata_d;
      reg_rvalid_q        <= reg_rd;
      irq_q               <= irq_d;
      pwrdn_irq_pin_o_n_q <= ~irq_d;
      pwrdn_irq_pin_oe_q  <= ctl_q[`CTL_OE];
      power_down_q        <= ~ctl_q[`CTL_OE] & ~pwrdn_irq_pin_i_n;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  chk_jabber_mirror: assert property (
    ##1 live_q[`SUM_JABBER] == $past(jabber_live))
    else $error("jabber summary bit does not follow input");
  chk_aneg_status: assert property (
    aneg_done |=> live_q[`SUM_ANEG])
    else $error("negotiation done not shown");
  chk_loop_status: assert property (
    !loopback_on |=> !live_q[`SUM_LOOP])
    else $error("loopback bit set in normal operation");
  chk_duplex_speed: assert property (
    ##1 live_q[`SUM_DUPLEX:`SUM_SPEED10]
        == $past({duplex_full, speed_is_10}))
    else $error("duplex or speed bit wrong");
  chk_link_hold: assert property (
    reg_rd && hit_sum && link_up ##1 link_up |=> live_q[`SUM_LINK])
    else $error("summary read disturbed link bit");
  chk_ctl_upper: assert property (
    reg_rd && hit_ctl |=> reg_rvalid_q && reg_rdata_q[15:3] == 13'h0000)
    else $error("reserved control bits not zero");
  chk_test_force: assert property (
    ctl_q[`CTL_TEST] |=> irq_q ##0 !pwrdn_irq_pin_o_n_q)
    else $error("test bit did not force interrupt");
  chk_global_off: assert property (
    !ctl_q[`CTL_EVT_EN] && !ctl_q[`CTL_TEST] |=> !irq_q)
    else $error("interrupt while events disabled");
  chk_pin_dir: assert property (
    wr_ctl |=> ##1 pwrdn_irq_pin_oe_q == $past(reg_wdata[`CTL_OE], 2))
    else $error("pin direction not from control bit");
  chk_evt_latch: assert property (
    evt_pulse[`EVT_LINK] |=> evt_stat_q[`EVT_LINK])
    else $error("link change not latched");
  chk_read_clear: assert property (
    rd_evt && evt_pulse == `EVT_ZERO |=> evt_stat_q == `EVT_ZERO)
    else $error("event read did not clear status");
  chk_pending_bit: assert property (
    reg_rd && hit_sum |=> reg_rdata_q[`SUM_PENDING] == $past(irq_q))
    else $error("pending bit does not match interrupt");
endmodule

// File: core/phy_stat_defs.svh
// Constants for the status summary and interrupt control block.
// Assumes a 5-bit management register address and 16-bit register data.
`ifndef PHY_STAT_DEFS_SVH
`define PHY_STAT_DEFS_SVH

// Management register addresses
`define ADDR_STATUS_SUMMARY 5'h10
`define ADDR_INT_CONTROL    5'h11
`define ADDR_INT_EVENT      5'h12

// Summary status field positions
`define SUM_LINK    0
`define SUM_SPEED10 1
`define SUM_DUPLEX  2
`define SUM_LOOP    3
`define SUM_ANEG    4
`define SUM_JABBER  5
`define SUM_PENDING 7

// Interrupt control field positions and writable mask
`define CTL_OE      0
`define CTL_EVT_EN  1
`define CTL_TEST    2
`define CTL_WIDTH   3

// Event register layout: status in the high byte, enables in the low byte
`define EVT_COUNT   8
`define EVT_STAT_LO 8
`define EVT_RX_HF   0
`define EVT_FC_HF   1
`define EVT_ANEG    2
`define EVT_DUPLEX  3
`define EVT_SPEED   4
`define EVT_LINK    5
`define EVT_ENERGY  6
`define EVT_LQ      7

// Reset values
`define WORD_ZERO   16'h0000
`define EVT_ZERO    8'h00
`define CTL_ZERO    3'h0

`endif

// File: core/phy_stat_pkg.sv
// Types shared by the status summary and interrupt control block.
// Assumes the constants header is included where numbers are needed.
package phy_stat_pkg;
  typedef logic [15:0] mgmt_word_t;
  typedef logic [4:0]  reg_addr_t;
  typedef logic [7:0]  evt_vec_t;
  typedef logic [2:0]  ctl_vec_t;
endpackage

// File: core/phy_evt_latch.sv
// Sticky event status bits with clear-on-read.
// Assumes event pulses and the read strobe are synchronous to ref_clk.
`timescale 1ns/100ps
`include "phy_stat_defs.svh"
module phy_evt_latch (
  // Clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  // Event pulses and clear strobe
  input  wire phy_stat_pkg::evt_vec_t  evt_pulse,
  input  wire logic                    clr_rd,
  // Latched status
  output      phy_stat_pkg::evt_vec_t  evt_stat_q
);
  import phy_stat_pkg::*;

  evt_vec_t stat_d;

  // One sticky flag per event; a new event beats the read clear
  for (genvar i = 0; i < `EVT_COUNT; i++) begin : g_evt
    assign stat_d[i] = evt_pulse[i] | (evt_stat_q[i] & ~clr_rd);
  end

  // One register for all flags, so each bit has a single driver
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_stat_q <= `EVT_ZERO;
    end else begin
      evt_stat_q <= stat_d;
    end
  end
endmodule

// File: bench/mgmt_ctl_model.sv
// Station management controller model issuing decoded accesses.
// Assumes strobes are taken at the rising edge of ref_clk.
`timescale 1ns/100ps
module mgmt_ctl_model (
  // Clock
  input  wire logic                     ref_clk,
  // Access side
  output      phy_stat_pkg::reg_addr_t  reg_addr,
  output      logic                     reg_wr,
  output      logic                     reg_rd,
  output      phy_stat_pkg::mgmt_word_t reg_wdata,
  input  wire phy_stat_pkg::mgmt_word_t reg_rdata_q,
  input  wire logic                     reg_rvalid_q
);
  import phy_stat_pkg::*;
  // Idle lines carry inverted values so stale data never passes
  initial begin
    reg_addr = 5'h1F;
    reg_wdata = 16'hFFFF;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // One-cycle write strobe
  task automatic wr(input reg_addr_t a, input mgmt_word_t v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask
  // Read; answer expected exactly one cycle after the strobe
  task automatic rd(input reg_addr_t a, output mgmt_word_t v);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    v = (reg_rvalid_q === 1'b1) ? reg_rdata_q : 16'hBAD0;
  endtask
endmodule

// File: bench/phy_status_irq_control_tb.sv
// Bench for the status summary and interrupt control block.
// Assumes the management model drives all register accesses.
`timescale 1ns/100ps
`include "phy_stat_defs.svh"
module phy_status_irq_control_tb;
  import phy_stat_pkg::*;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  reg_addr_t  reg_addr;
  logic       reg_wr, reg_rd, rvalid, pin_o_n, pin_oe, pwr_dn;
  mgmt_word_t reg_wdata, rdata, d;
  logic       jab = 0, aneg = 0, loop = 0, dup = 0, spd = 0, link = 0;
  logic       energy = 0, pin_n = 1'b1;
  logic       lq = 0, fch = 0, rxh = 0;
  int         failures = 0, cmp_count = 0;
  // Pin level: device drive wins, otherwise the bench (pulled high)
  wire        pin_lvl = pin_oe ? pin_o_n : pin_n;
  always #2.5 ref_clk = ~ref_clk;
  mgmt_ctl_model i_mgmt (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_q(rdata), .reg_rvalid_q(rvalid));
  phy_status_irq_control i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .jabber_live(jab), .aneg_done(aneg), .loopback_on(loop),
    .duplex_full(dup), .speed_is_10(spd), .link_up(link),
    .energy_seen(energy), .link_quality_evt(lq), .fc_cnt_half(fch),
    .rxerr_cnt_half(rxh), .pwrdn_irq_pin_i_n(pin_lvl),
    .pwrdn_irq_pin_o_n_q(pin_o_n), .pwrdn_irq_pin_oe_q(pin_oe),
    .power_down_q(pwr_dn));
  task automatic chk(input mgmt_word_t got, input mgmt_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic results;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Hang guard, far beyond the fewer than a hundred cycles the tests need
  initial begin
    #20000;
    failures++;
    results();
  end
  initial begin
    cyc(5);
    sys_rst = 1'b0;
    // Reset values of all registers and of the pin
    for (int i = 0; i < 3; i++) begin
      i_mgmt.rd(`ADDR_STATUS_SUMMARY + 5'(i), d);
      chk(d, 16'h0000);
    end
    chk(16'({pin_oe, pin_o_n, pwr_dn}), 16'h0002);
    $display("test reset done");
    // Live summary bits, read twice to show reads do not clear
    {jab, aneg, loop, dup, spd, link} = 6'h35;
    cyc(3);
    i_mgmt.rd(`ADDR_STATUS_SUMMARY, d);
    chk(d, 16'h0035);
    i_mgmt.rd(`ADDR_STATUS_SUMMARY, d);
    chk(d, 16'h0035);
    i_mgmt.rd(`ADDR_INT_EVENT, d);
    chk(d & 16'h2000, 16'h2000);
    {jab, aneg, loop, dup, spd, link} = 6'h0A;
    cyc(3);
    i_mgmt.rd(`ADDR_STATUS_SUMMARY, d);
    chk(d, 16'h000A);
    $display("test summary done");
    // Control: reserved bits, test force, pin output select
    i_mgmt.wr(`ADDR_INT_CONTROL, 16'hFFFF);
    i_mgmt.rd(`ADDR_INT_CONTROL, d);
    chk(d, 16'h0007);
    chk(16'({pin_oe, pin_o_n}), 16'h0002);
    i_mgmt.rd(`ADDR_STATUS_SUMMARY, d);
    chk(d, 16'h008A);
    i_mgmt.wr(`ADDR_INT_CONTROL, 16'h0001);
    cyc(3);
    chk(16'({pin_oe, pin_o_n}), 16'h0003);
    $display("test control done");
    // Event path: global enable gates, read clears pending
    i_mgmt.wr(`ADDR_INT_EVENT, 16'h0020);
    i_mgmt.rd(`ADDR_INT_EVENT, d);
    link = 1'b1;
    energy = 1'b1;
    cyc(5);
    chk(16'(pin_o_n), 16'h0001);
    i_mgmt.wr(`ADDR_INT_CONTROL, 16'h0003);
    cyc(3);
    chk(16'(pin_o_n), 16'h0000);
    i_mgmt.rd(`ADDR_INT_EVENT, d);
    chk(d, 16'h6020);
    cyc(3);
    chk(16'(pin_o_n), 16'h0001);
    $display("test events done");
    // Pin as power-down input, then an unmapped read
    i_mgmt.wr(`ADDR_INT_CONTROL, 16'h0000);
    pin_n = 1'b0;
    cyc(3);
    chk(16'({pin_oe, pwr_dn}), 16'h0001);
    pin_n = 1'b1;
    i_mgmt.rd(5'h1F, d);
    chk(d, 16'h0000);
    $display("test pin done");
    // Quality pulse and half-full edges latch but stay unenabled
    i_mgmt.wr(`ADDR_INT_CONTROL, 16'h0003);
    lq = 1'b1;
    fch = 1'b1;
    rxh = 1'b1;
    cyc(1);
    lq = 1'b0;
    cyc(3);
    chk(16'(pin_o_n), 16'h0001);
    i_mgmt.rd(`ADDR_INT_EVENT, d);
    chk(d, 16'h8320);
    i_mgmt.rd(`ADDR_INT_EVENT, d);
    chk(d, 16'h0020);
    $display("test sources done");
    results();
  end
endmodule
